// ===== core/mcs_defs.svh
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
`define MCS_ADDR_W       19
`define MCS_CHAR_W       6
`define MCS_BANK_W       12
`define MCS_SECTOR_W     15
`define MCS_ADDR_MAX     19'h7_FFFF
`define MCS_VAR_TRAP_BIT 2
`define MCS_VAR_SPEC_BIT 3
`define MCS_VAR_W_LO     4
`define MCS_VAR_W_TWO    2'h1
`define MCS_VAR_W_FOUR   2'h3
`define MCS_CHARS_TWO    3'h2
`define MCS_CHARS_THREE  3'h3
`define MCS_CHARS_FOUR   3'h4
`endif

// ===== core/mcs_mode_seq.sv
`timescale 1ns/1ns
`include "mcs_defs.svh"
module mcs_mode_seq (
  input  wire logic                        clock,         // System clock
  input  wire logic                        rst_n,         // Async reset, active low
  input  wire logic                        opValid,       // Decoded op presented, one cycle
  input  wire logic                        modeOp,        // Op is change_addressing_mode_op
  input  wire logic                        seqOp,         // Op is change_sequencing_op
  input  wire logic                        opMarked,      // Op char has item or record mark
  input  wire mcs_pkg::mcs_fmt_type        opFmt,         // Operand format of the op
  input  wire logic [`MCS_CHAR_W-1:0]      variantIn,     // Variant character of the op
  input  wire logic [`MCS_ADDR_W-1:0]      aAddrIn,       // Raw A address field
  input  wire logic [`MCS_ADDR_W-1:0]      bAddrIn,       // Raw B address field
  input  wire logic [`MCS_ADDR_W-1:0]      nextAddr,      // Next instruction address
  input  wire logic                        altLoad,       // Load alternate sequence reg
  input  wire logic [`MCS_ADDR_W-1:0]      altLoadVal,    // Value for alternate load
  input  wire logic                        seqLoad,       // Normal sequence advance
  output mcs_pkg::mcs_width_type           addrWidth_r,   // Current addressing width
  output logic [2:0]                       addrChars_r,   // Address chars to fetch
  output logic                             trapMode_r,    // Trap mode active
  output logic                             specMode_r,    // Special mode active
  output logic                             execSeq_r,     // Sequence change executed, pulse
  output logic                             suppressOp_r,  // Original op suppressed, pulse
  output logic                             wordMarkWe_r,  // Word-mark write enable
  output logic [`MCS_ADDR_W-1:0]           seqReg_r,      // Sequence register
  output logic [`MCS_ADDR_W-1:0]           altSeqReg_r,   // Alternate sequence register
  output logic [`MCS_ADDR_W-1:0]           aOperandReg_r, // A operand address register
  output logic [`MCS_ADDR_W-1:0]           bOperandReg_r, // B operand address register
  output logic [`MCS_CHAR_W-1:0]           variantReg_r   // Variant register
);
  import mcs_pkg::*;

  // ==========================================================
  // Decode
  // ==========================================================
  logic                   doTrap;
  logic                   doSeq;
  logic                   doMode;
  mcs_width_type          width_nxt;
  logic [`MCS_ADDR_W-1:0] aEff;
  logic [`MCS_ADDR_W-1:0] bEff;

  assign doTrap = opValid && trapMode_r && opMarked;
  assign doSeq  = opValid && (seqOp || doTrap);
  assign doMode = opValid && modeOp && !doTrap;

  always_comb begin
    case (variantIn[`MCS_CHAR_W-1:`MCS_VAR_W_LO])
      `MCS_VAR_W_TWO:  width_nxt = MCS_W2;
      `MCS_VAR_W_FOUR: width_nxt = MCS_W4;
      default:         width_nxt = MCS_W3;
    endcase
  end

  // Bank or sector bits come from the current sequence address
  function automatic logic [`MCS_ADDR_W-1:0] reach(
    input mcs_width_type w, input logic [`MCS_ADDR_W-1:0] raw,
    input logic [`MCS_ADDR_W-1:0] base);
    case (w)
      MCS_W2:  reach = {base[`MCS_ADDR_W-1:`MCS_BANK_W], raw[`MCS_BANK_W-1:0]};
      MCS_W3:  reach = {base[`MCS_ADDR_W-1:`MCS_SECTOR_W], raw[`MCS_SECTOR_W-1:0]};
      default: reach = raw & `MCS_ADDR_MAX;
    endcase
  endfunction : reach

  assign aEff = reach(addrWidth_r, aAddrIn, seqReg_r);
  assign bEff = reach(addrWidth_r, bAddrIn, seqReg_r);

  // ==========================================================
  // Mode state
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrWidth_r <= MCS_W3;
      trapMode_r  <= 1'b0;
      specMode_r  <= 1'b0;
    end else if (doMode) begin
      addrWidth_r <= width_nxt;
      trapMode_r  <= variantIn[`MCS_VAR_TRAP_BIT];
      specMode_r  <= variantIn[`MCS_VAR_SPEC_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrChars_r <= `MCS_CHARS_THREE;
    end else begin
      case (doMode ? width_nxt : addrWidth_r)
        MCS_W2:  addrChars_r <= `MCS_CHARS_TWO;
        MCS_W4:  addrChars_r <= `MCS_CHARS_FOUR;
        default: addrChars_r <= `MCS_CHARS_THREE;
      endcase
    end
  end

  // ==========================================================
  // Pulses
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      execSeq_r    <= 1'b0;
      suppressOp_r <= 1'b0;
      wordMarkWe_r <= 1'b0;
    end else begin
      execSeq_r    <= doSeq;
      suppressOp_r <= doTrap;
      wordMarkWe_r <= 1'b0;
    end
  end

  // ==========================================================
  // Sequence registers
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seqReg_r    <= '0;
      altSeqReg_r <= '0;
    end else if (doSeq) begin
      seqReg_r    <= altSeqReg_r;
      altSeqReg_r <= nextAddr;
    end else begin
      if (doMode || seqLoad) begin
        seqReg_r <= nextAddr;
      end
      if (altLoad) begin
        altSeqReg_r <= altLoadVal;
      end
    end
  end

  // ==========================================================
  // Operand registers
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aOperandReg_r <= '0;
      bOperandReg_r <= '0;
      variantReg_r  <= '0;
    end else if (doSeq) begin
      if (opFmt != MCS_FMT_NONE) begin
        aOperandReg_r <= aEff;
      end
      if (opFmt == MCS_FMT_AB || opFmt == MCS_FMT_ABV) begin
        bOperandReg_r <= bEff;
      end
      if (opFmt == MCS_FMT_ABV) begin
        variantReg_r <= variantIn;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  AST_TRAP_SWAP: assert property (@(posedge clock) disable iff (!rst_n)
    doTrap |=> execSeq_r && suppressOp_r && seqReg_r == $past(altSeqReg_r))
    else $error("Trapped op did not swap sequence");
  AST_SWAP_ALT: assert property (@(posedge clock) disable iff (!rst_n)
    doSeq |=> altSeqReg_r == $past(nextAddr))
    else $error("Alternate register missed next address");
  AST_MODE_W2: assert property (@(posedge clock) disable iff (!rst_n)
    (doMode && variantIn[5:4] == 2'h1) |=> addrWidth_r == MCS_W2 && addrChars_r == 3'h2)
    else $error("Two-character mode not selected");
  AST_MODE_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    doMode |=> trapMode_r == $past(variantIn[2]) && specMode_r == $past(variantIn[3]))
    else $error("Trap or special flag wrong");
  AST_MODE_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    doMode |=> $stable(aOperandReg_r) && $stable(bOperandReg_r)
      && seqReg_r == $past(nextAddr))
    else $error("Mode op disturbed address registers");
  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !doMode |=> $stable(addrWidth_r))
    else $error("Width changed without mode op");
  AST_A_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt == MCS_FMT_A) |=> $stable(bOperandReg_r) && $stable(variantReg_r))
    else $error("A-only form touched B or variant");
  AST_FULL: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt == MCS_FMT_ABV) |=> variantReg_r == $past(variantIn))
    else $error("Variant not loaded");
  AST_NO_WM: assert property (@(posedge clock) disable iff (!rst_n)
    !wordMarkWe_r)
    else $error("Word mark write raised");
  AST_REACH2: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt != MCS_FMT_NONE && addrWidth_r == MCS_W2)
      |=> aOperandReg_r[18:12] == $past(seqReg_r[18:12]))
    else $error("Two-character address left its bank");

  // ==========================================================
  // Further checks
  // ==========================================================
  // Width decode for the wider modes
  AST_MODE_W3: assert property (@(posedge clock) disable iff (!rst_n)
    (doMode && variantIn[4] == 1'b0) |=> addrWidth_r == MCS_W3 && addrChars_r == 3'h3)
    else $error("Three-character mode not selected");

  AST_MODE_W4: assert property (@(posedge clock) disable iff (!rst_n)
    (doMode && variantIn[5:4] == 2'h3) |=> addrWidth_r == MCS_W4 && addrChars_r == 3'h4)
    else $error("Four-character mode not selected");

  // Fetch count always follows the held width
  AST_CHARS_TRACK: assert property (@(posedge clock) disable iff (!rst_n)
    addrChars_r == ((addrWidth_r == MCS_W2) ? 3'h2 : (addrWidth_r == MCS_W4) ? 3'h4 : 3'h3))
    else $error("Fetch count does not match width");

  AST_TRAP_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !doMode |=> $stable(trapMode_r))
    else $error("Trap flag changed without mode op");

  AST_SPEC_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !doMode |=> $stable(specMode_r))
    else $error("Special flag changed without mode op");

  AST_NO_TRAP_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    (opValid && !trapMode_r) |=> !suppressOp_r)
    else $error("Op suppressed outside trap mode");

  AST_SUPP_EXEC: assert property (@(posedge clock) disable iff (!rst_n)
    suppressOp_r |-> execSeq_r)
    else $error("Suppressed op without sequence change");

  // A trapped mode op must not reach the mode state
  AST_TRAP_NO_MODE: assert property (@(posedge clock) disable iff (!rst_n)
    doTrap |=> $stable(addrWidth_r) && $stable(trapMode_r) && $stable(specMode_r))
    else $error("Trapped op changed the mode");

  AST_TRAP_OPS: assert property (@(posedge clock) disable iff (!rst_n)
    (doTrap && opFmt == MCS_FMT_ABV && addrWidth_r == MCS_W4)
      |=> aOperandReg_r == $past(aAddrIn) && bOperandReg_r == $past(bAddrIn)
      && variantReg_r == $past(variantIn))
    else $error("Trapped operands not routed");

  AST_SEQ_JUMP: assert property (@(posedge clock) disable iff (!rst_n)
    doSeq |=> seqReg_r == $past(altSeqReg_r))
    else $error("Sequence change did not branch");

  AST_EXEC_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
    !doSeq |=> !execSeq_r)
    else $error("Sequence pulse without sequence change");

  AST_NONE_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt == MCS_FMT_NONE) |=> $stable(aOperandReg_r) && $stable(bOperandReg_r)
      && $stable(variantReg_r))
    else $error("Bare form touched operand registers");

  AST_A_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt == MCS_FMT_A && addrWidth_r == MCS_W4)
      |=> aOperandReg_r == $past(aAddrIn))
    else $error("A-only form did not load A");

  AST_AB_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt == MCS_FMT_AB && addrWidth_r == MCS_W4)
      |=> aOperandReg_r == $past(aAddrIn) && bOperandReg_r == $past(bAddrIn)
      && $stable(variantReg_r))
    else $error("A and B form did not load both");

  // Reach: upper bits come from the current sequence address
  AST_REACH3: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt != MCS_FMT_NONE && addrWidth_r == MCS_W3)
      |=> aOperandReg_r[18:15] == $past(seqReg_r[18:15]))
    else $error("Three-character address left its sector");

  AST_REACH2B: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && (opFmt == MCS_FMT_AB || opFmt == MCS_FMT_ABV) && addrWidth_r == MCS_W2)
      |=> bOperandReg_r[18:12] == $past(seqReg_r[18:12]))
    else $error("Two-character B address left its bank");

  AST_LOW_BITS2: assert property (@(posedge clock) disable iff (!rst_n)
    (doSeq && opFmt != MCS_FMT_NONE && addrWidth_r == MCS_W2)
      |=> aOperandReg_r[11:0] == $past(aAddrIn[11:0]))
    else $error("Two-character address bits lost");

  AST_MODE_NO_VAR: assert property (@(posedge clock) disable iff (!rst_n)
    (doMode && !seqOp) |=> $stable(variantReg_r) && !execSeq_r)
    else $error("Mode op touched variant or sequence pulse");

  AST_MODE_ALT: assert property (@(posedge clock) disable iff (!rst_n)
    (doMode && !seqOp && !altLoad) |=> $stable(altSeqReg_r))
    else $error("Mode op changed alternate register");

  // Alternate register load from the control-register path
  AST_ALT_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (altLoad && !doSeq) |=> altSeqReg_r == $past(altLoadVal))
    else $error("Alternate register load lost");

  AST_IDLE_SEQ: assert property (@(posedge clock) disable iff (!rst_n)
    (!doSeq && !doMode && !seqLoad) |=> $stable(seqReg_r))
    else $error("Sequence register moved while idle");

  AST_IDLE_OPS: assert property (@(posedge clock) disable iff (!rst_n)
    !doSeq |=> $stable(aOperandReg_r) && $stable(bOperandReg_r) && $stable(variantReg_r))
    else $error("Operand registers moved without sequence change");

  AST_MARK_PLAIN: assert property (@(posedge clock) disable iff (!rst_n)
    (opValid && opMarked && !trapMode_r && !seqOp) |=> !execSeq_r)
    else $error("Marked op trapped outside trap mode");

  AST_SEQ_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    (seqLoad && !doSeq) |=> seqReg_r == $past(nextAddr))
    else $error("Sequence advance lost");
endmodule : mcs_mode_seq

// ===== core/mcs_pkg.sv
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_W2,
    MCS_W3,
    MCS_W4
  } mcs_width_type;
  typedef enum logic [1:0] {
    MCS_FMT_NONE,
    MCS_FMT_A,
    MCS_FMT_AB,
    MCS_FMT_ABV
  } mcs_fmt_type;
endpackage : mcs_pkg

// ===== tb/mcs_tb.sv
`timescale 1ns/1ns
`include "mcs_defs.svh"
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb;
  import mcs_pkg::*;
  logic          clock, rst_n, opValid, modeOp, seqOp, opMarked, altLoad, seqLoad;
  mcs_fmt_type   opFmt;
  logic [5:0]    variantIn, expV;
  logic [18:0]   aAddrIn, bAddrIn, nextAddr, altLoadVal, seqR, altR, aR, bR;
  logic [18:0]   expSr, expAlt, expA, expB;
  mcs_width_type addrW, expW;
  logic [2:0]    chars;
  logic [5:0]    varR;
  logic          trapR, specR, execR, suppR, wmWe, expTrap, expSpec;
  int            failures, tests_run;
  mcs_mode_seq DUT (.clock(clock), .rst_n(rst_n), .opValid(opValid), .modeOp(modeOp),
    .seqOp(seqOp), .opMarked(opMarked), .opFmt(opFmt), .variantIn(variantIn),
    .aAddrIn(aAddrIn), .bAddrIn(bAddrIn), .nextAddr(nextAddr), .altLoad(altLoad),
    .altLoadVal(altLoadVal), .seqLoad(seqLoad), .addrWidth_r(addrW), .addrChars_r(chars),
    .trapMode_r(trapR), .specMode_r(specR), .execSeq_r(execR), .suppressOp_r(suppR),
    .wordMarkWe_r(wmWe), .seqReg_r(seqR), .altSeqReg_r(altR), .aOperandReg_r(aR),
    .bOperandReg_r(bR), .variantReg_r(varR));
  // ==========================================
  // Reference model and checks
  function automatic logic [18:0] fit(input mcs_width_type w, input logic [18:0] raw, base);
    case (w)
      MCS_W2: fit = {base[18:12], raw[11:0]};
      MCS_W3: fit = {base[18:15], raw[14:0]};
      default: fit = raw;
    endcase
  endfunction : fit
  task automatic checkAll(input logic sq, input logic tr);
    `CHK("width", expW, addrW)
    `CHK("chars", (expW == MCS_W2) ? 3'd2 : (expW == MCS_W4) ? 3'd4 : 3'd3, chars)
    `CHK("trap", expTrap, trapR)
    `CHK("spec", expSpec, specR)
    `CHK("seq", expSr, seqR)
    `CHK("alt", expAlt, altR)
    `CHK("aop", expA, aR)
    `CHK("bop", expB, bR)
    `CHK("var", expV, varR)
    `CHK("exec", sq, execR)
    `CHK("wmwe", 1'b0, wmWe)
    `CHK("supp", tr, suppR)
  endtask : checkAll
  task automatic issue(input logic m, s, k, input mcs_fmt_type f, input logic [5:0] v,
                       input logic [18:0] a, b);
    logic sq;
    logic tr;
    tr = expTrap & k;
    sq = s | tr;
    modeOp = m; seqOp = s; opMarked = k; opFmt = f; variantIn = v;
    aAddrIn = a; bAddrIn = b; nextAddr = ~a; seqLoad = m; opValid = 1;
    @(posedge clock);
    #1 opValid = 0;
    seqLoad = 0;
    if (sq) begin
      if (f != MCS_FMT_NONE) expA = fit(expW, a, expSr);
      if (f == MCS_FMT_AB || f == MCS_FMT_ABV) expB = fit(expW, b, expSr);
      if (f == MCS_FMT_ABV) expV = v;
      expSr = expAlt;
      expAlt = ~a;
    end else if (m) begin
      expW = (v[5:4] == 2'h1) ? MCS_W2 : (v[5:4] == 2'h3) ? MCS_W4 : MCS_W3;
      expTrap = v[2];
      expSpec = v[3];
      expSr = ~a;
    end
    checkAll(sq, tr);
    @(posedge clock);
    #1;
  endtask : issue
  task automatic test_reset;
    rst_n = 0;
    @(posedge clock);
    #1 rst_n = 1;
    {expSr, expAlt, expA, expB, expV, expTrap, expSpec} = '0;
    expW = MCS_W3;
    checkAll(0, 0);
  endtask : test_reset
  // ==========================================
  // Scenarios
  task automatic test_modes;
    logic [5:0] tbl [14] = '{6'o20, 6'o00, 6'o40, 6'o60, 6'o24, 6'o04, 6'o44, 6'o64,
                             6'o30, 6'o10, 6'o70, 6'o34, 6'o14, 6'o74};
    foreach (tbl[i]) issue(1, 0, 0, MCS_FMT_ABV, tbl[i], 19'h1_2345, 19'h2_3456);
  endtask : test_modes
  task automatic test_formats;
    issue(1, 0, 0, MCS_FMT_NONE, 6'o60, 19'h0_0100, 19'h0);
    altLoad = 1;
    altLoadVal = 19'h5_1234;
    @(posedge clock);
    #1 altLoad = 0;
    expAlt = 19'h5_1234;
    for (int f = 0; f < 4; f++) issue(0, 1, 0, mcs_fmt_type'(f), 6'o13 + 6'(f),
      19'h7_0F00 + 19'(f), 19'h3_00A0 + 19'(f));
  endtask : test_formats
  task automatic test_trap;
    issue(1, 0, 0, MCS_FMT_NONE, 6'o64, 19'h4_4444, 19'h0);
    issue(1, 0, 1, MCS_FMT_ABV, 6'o20, 19'h6_1357, 19'h2_468A);
    issue(1, 0, 0, MCS_FMT_NONE, 6'o60, 19'h1_1111, 19'h0);
    issue(0, 0, 1, MCS_FMT_AB, 6'o77, 19'h0_0777, 19'h0_0666);
  endtask : test_trap
  task automatic test_narrow;
    issue(1, 0, 0, MCS_FMT_NONE, 6'o20, 19'h5_A5A5, 19'h0);
    issue(0, 1, 0, MCS_FMT_AB, 6'o00, 19'h7_FFFF, 19'h2_BCDE);
    issue(1, 0, 0, MCS_FMT_NONE, 6'o00, 19'h6_9696, 19'h0);
    issue(0, 1, 0, MCS_FMT_A, 6'o00, 19'h7_FFFF, 19'h0);
  endtask : test_narrow
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Clock, reset, sequence
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  initial begin
    #200_000 failures++;
    report_and_stop;
  end
  initial begin
    {rst_n, opValid, modeOp, seqOp, opMarked, altLoad, seqLoad} = '0;
    opFmt = MCS_FMT_NONE; variantIn = '0; aAddrIn = '0; bAddrIn = '0;
    nextAddr = '0; altLoadVal = '0; failures = 0; tests_run = 0;
    {expSr, expAlt, expA, expB, expV, expTrap, expSpec} = '0;
    expW = MCS_W3;
    repeat (12) @(posedge clock);
    #1 rst_n = 1;
    checkAll(0, 0);
    test_modes;
    test_formats;
    test_trap;
    test_reset;
    test_narrow;
    report_and_stop;
  end
endmodule : tb
